// file: logic/mcs_regs.svh
// constants for the microcode store maintenance block
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
`define MCS_MAINT_ADDR_W  13
`define MCS_HALF_BIT      12
`define MCS_ADDR_W        12
`define MCS_WORD_W        47
`define MCS_BANK_ROM      2'h0
`define MCS_BANK_RAM1     2'h1
`define MCS_BANK_RAM2     2'h2
`define MCS_RAM_DEPTH     2048
`define MCS_FLAG_DEPTH    3072
`define MCS_FLAG_IN_BIT   15
`define MCS_MAINT_ADDR_RESET 13'h0000
`endif

// file: logic/mcs_pkg.sv
// types shared by the microcode store maintenance block
package mcs_pkg;
   // one stored microword with its sync flag, msb first
   typedef struct packed {
      logic        sync_flag_bit;
      logic [14:0] hi;
      logic [15:0] mid;
      logic [15:0] lo;
   } mcs_word_t;

   // start-up state, one-hot
   typedef enum logic [1:0] {
      MCS_UNINIT = 2'b01,
      MCS_RUN    = 2'b10
   } mcs_state_t;
endpackage

// file: logic/mcs_store.sv
// microcode control store with maintenance read and write path
`timescale 1ns/100ps
`include "mcs_regs.svh"
module mcs_store
   import mcs_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   input  wire logic [31:0] i_internal_bus_input,
   input  wire logic        i_load_maint_address,
   input  wire logic        i_store_write,
   input  wire logic        i_data_in_enable,
   input  wire logic        i_local_store_select_bit,
   input  wire logic [11:0] i_sequencer_address,
   input  wire logic        i_maintenance_clear,
   input  wire logic        i_start_run,
   output logic [31:0]      o_misc_readback_bus,
   output mcs_word_t        o_microword,
   output logic             o_microword_valid,
   output logic [11:0]      o_store_address_bits,
   output logic             o_maint_source_enable,
   output logic             o_sequencer_source_enable
);

   ////////////////////////////////////////////////////////////////////////
   // reset release and state

   logic        rst_meta;
   logic        rst_n;
   mcs_state_t  state;
   mcs_state_t  next_state;
   logic [12:0] maint_store_address;

   // async assert, two-flop release so every flop leaves reset together
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // clear wins over start so a stray start cannot skip maintenance
   always_comb
   begin
      next_state = state;
      case (state)
         MCS_UNINIT:
            if (i_start_run && !i_maintenance_clear)
               next_state = MCS_RUN;
         MCS_RUN:
            if (i_maintenance_clear)
               next_state = MCS_UNINIT;
         default:
            next_state = MCS_UNINIT;
      endcase
   end

   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         state <= MCS_UNINIT;
      else
         state <= next_state;
   end

   // maintenance address register, loaded from the internal bus
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         maint_store_address <= `MCS_MAINT_ADDR_RESET;
      else if (i_load_maint_address)
         maint_store_address <= i_internal_bus_input[12:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // address source and bank decode

   logic        maint_mode;
   logic        half_sel;
   logic [11:0] store_addr;
   logic [2:0]  bank_en;
   logic [10:0] ram_idx;

   assign maint_mode = (state == MCS_UNINIT);
   assign half_sel   = maint_store_address[`MCS_HALF_BIT];
   // only one source reaches the shared lines
   assign store_addr = maint_mode ? maint_store_address[11:0]
                                  : i_sequencer_address;
   // bank 3 is unpopulated: no enable, reads as zero
   assign bank_en[0] = (store_addr[11:10] == `MCS_BANK_ROM);
   assign bank_en[1] = (store_addr[11:10] == `MCS_BANK_RAM1);
   assign bank_en[2] = (store_addr[11:10] == `MCS_BANK_RAM2);
   assign ram_idx    = {store_addr[11], store_addr[9:0]} - 11'h400;

   // start-up outputs and the registered address lines
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_maint_source_enable     <= 1'b1;
         o_sequencer_source_enable <= 1'b0;
         o_store_address_bits      <= 12'h000;
      end
      else
      begin
         o_maint_source_enable     <= (next_state == MCS_UNINIT);
         o_sequencer_source_enable <= (next_state == MCS_RUN);
         o_store_address_bits      <= store_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // storage

   logic [15:0] ram_lo   [0:`MCS_RAM_DEPTH-1];
   logic [15:0] ram_mid  [0:`MCS_RAM_DEPTH-1];
   logic [14:0] ram_hi   [0:`MCS_RAM_DEPTH-1];
   logic        flag_ram [0:`MCS_FLAG_DEPTH-1];
   logic        write_low_part;
   logic        write_high_part;
   logic        write_in_progress;
   logic        ram_bank;

   // fixed read-only bank pattern, stands in for the mask contents
   function automatic logic [46:0] rom_word(input logic [9:0] a);
      rom_word = 47'({5{a}});
   endfunction

   // writes only on the maintenance address with data-in enabled
   assign write_in_progress = i_store_write && maint_mode;
   assign ram_bank          = bank_en[1] || bank_en[2];
   assign write_low_part  = write_in_progress && i_data_in_enable
                            && !half_sel;
   assign write_high_part = write_in_progress && i_data_in_enable
                            && half_sel;

   // two separately enabled parts, lo and mid together, hi alone; rom bank never written
   always_ff @(posedge i_clock)
   begin
      if (write_low_part && ram_bank)
      begin
         ram_lo[ram_idx]  <= i_internal_bus_input[15:0];
         ram_mid[ram_idx] <= i_internal_bus_input[31:16];
      end
      if (write_high_part && ram_bank)
         ram_hi[ram_idx] <= i_internal_bus_input[14:0];
   end

   // flag store covers all three banks, the rom bank included
   always_ff @(posedge i_clock)
   begin
      if (write_high_part && store_addr[11:10] != 2'h3)
         flag_ram[store_addr] <= i_internal_bus_input[`MCS_FLAG_IN_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // read path and maintenance mux

   mcs_word_t   rd_word;
   logic [31:0] next_readback;

   always_comb
   begin
      rd_word = '0;
      if (bank_en[0])
         rd_word[46:0] = rom_word(store_addr[9:0]);
      else if (ram_bank)
         rd_word[46:0] = {ram_hi[ram_idx], ram_mid[ram_idx],
                          ram_lo[ram_idx]};
      if (store_addr[11:10] != 2'h3)
         rd_word.sync_flag_bit = flag_ram[store_addr];
   end

   // table: select bit wins, then half bit picks the word half
   always_comb
   begin
      if (i_local_store_select_bit)
         next_readback = {19'h00000, maint_store_address};
      else if (half_sel)
         next_readback = {16'h0000, rd_word[47:32]};
      else
         next_readback = rd_word[31:0];
   end

   // the bus carries store data only while uninitialized
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_microword         <= '0;
         o_microword_valid   <= 1'b0;
         o_misc_readback_bus <= 32'h00000000;
      end
      else
      begin
         o_microword         <= rd_word;
         o_microword_valid   <= !write_in_progress;
         o_misc_readback_bus <= maint_mode ? next_readback
                                           : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_high_write;
      write_high_part && ram_bank && !i_load_maint_address && !i_start_run;
   endsequence
   sequence s_quiet_read;
      !i_store_write && !i_load_maint_address && !i_maintenance_clear;
   endsequence

   chk_readback_addr: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      maint_mode && i_local_store_select_bit |=>
      o_misc_readback_bus == {19'h00000, $past(maint_store_address)})
      else $error("readback of maintenance address wrong");

   chk_readback_low: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      maint_mode && !i_local_store_select_bit && !half_sel |=>
      o_misc_readback_bus == o_microword[31:0])
      else $error("low half readback wrong");

   chk_readback_high: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      maint_mode && !i_local_store_select_bit && half_sel |=>
      o_misc_readback_bus == {16'h0000, o_microword[47:32]})
      else $error("high half readback wrong");

   chk_write_blanks: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      write_in_progress |=> !o_microword_valid)
      else $error("word shown during a write");

   chk_source_onehot: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      o_maint_source_enable != o_sequencer_source_enable)
      else $error("address source enables not exclusive");

   chk_clear_uninit: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      i_maintenance_clear |=> o_maint_source_enable && maint_mode)
      else $error("maintenance clear ignored");

   chk_seq_address: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      !maint_mode |=> o_store_address_bits == $past(i_sequencer_address))
      else $error("sequencer address not passed");

   chk_high_write: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      s_high_write ##1 s_quiet_read |=>
      o_microword.hi == $past(i_internal_bus_input[14:0], 2))
      else $error("high part write lost");

   chk_rom_flag: assert property (
      @(posedge i_clock) disable iff (!rst_n)
      write_high_part && bank_en[0] && !i_load_maint_address && !i_start_run
      ##1 s_quiet_read |=>
      o_microword.sync_flag_bit == $past(i_internal_bus_input[15], 2)
      && o_microword[46:0] == rom_word($past(store_addr[9:0], 2)))
      else $error("rom bank write misbehaved");

endmodule // mcs_store

// file: tb/mcs_dp_model.sv
// data path side model driving the store maintenance inputs
`timescale 1ns/100ps
module mcs_path_model
(
   input  wire logic        i_clock,
   output logic [31:0]      o_bus,
   output logic             o_load,
   output logic             o_write,
   output logic             o_den,
   output logic             o_select
);
   // idle levels from time zero
   initial
   begin
      o_bus = 32'h0;
      o_load = 1'b0;
      o_write = 1'b0;
      o_den = 1'b0;
      o_select = 1'b0;
   end
   ////////////////////////////////////////
   // address load; select held until the next load
   task automatic load(input logic [12:0] a, input logic s);
      @(posedge i_clock);
      #1;
      o_bus = {19'h0, a};
      o_load = 1'b1;
      o_select = s;
      @(posedge i_clock);
      #1;
      o_load = 1'b0;
      o_bus = ~o_bus; // released bus must not keep old value
   endtask
   // one write strobe cycle, data-in enable as asked
   task automatic write(input logic [31:0] d, input logic e);
      @(posedge i_clock);
      #1;
      o_bus = d;
      o_write = 1'b1;
      o_den = e;
      @(posedge i_clock);
      #1;
      o_write = 1'b0;
      o_den = 1'b0;
      o_bus = ~d;
   endtask
endmodule // mcs_path_model

// file: tb/mcs_store_tb_top.sv
// self-checking bench for the microcode store maintenance path
`timescale 1ns/100ps
module mcs_store_tb_top
   import mcs_pkg::*;
   ;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic [11:0] seq_addr = 12'h000;
   logic        clear_req = 1'b0;
   logic        run = 1'b0;
   logic [31:0] bus, rb;
   logic        load, wr_s, den, sel, vld, men, sen;
   mcs_word_t   wd;
   logic [11:0] addr_lines;
   int          err_count = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [46:0] wrd [4096];
   logic        flg [4096];
   logic [12:0] a, r;
   logic [47:0] keep;
   logic [12:0] corner [3];

   always #20 clock = ~clock;
   // hang guard, far above the expected run length
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         err_count = err_count + 1;
         report_and_stop();
      end
   end
   ////////////////////////////////////////
   mcs_path_model u_mcs_path_model
   (
      .i_clock(clock), .o_bus(bus), .o_load(load), .o_write(wr_s),
      .o_den(den), .o_select(sel)
   );
   mcs_store u_mcs_store
   (
      .i_clock(clock), .i_resetn(resetn), .i_internal_bus_input(bus),
      .i_load_maint_address(load), .i_store_write(wr_s),
      .i_data_in_enable(den), .i_local_store_select_bit(sel),
      .i_sequencer_address(seq_addr), .i_maintenance_clear(clear_req),
      .i_start_run(run), .o_misc_readback_bus(rb), .o_microword(wd),
      .o_microword_valid(vld), .o_store_address_bits(addr_lines),
      .o_maint_source_enable(men), .o_sequencer_source_enable(sen)
   );
   ////////////////////////////////////////
   task automatic cy(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checked = checked + 1;
      if (seen !== exp)
         $display("Error at %0t: saw %h want %h", $time, seen, exp);
      if (seen !== exp)
         err_count = err_count + 1;
   endtask
   // readback expected from the bench copy of the store
   function automatic logic [31:0] exp_rb(input logic [12:0] x,
                                          input logic s);
      if (s)
         return {19'h0, x};
      if (x[12])
         return {16'h0, flg[x[11:0]], wrd[x[11:0]][46:32]};
      return wrd[x[11:0]][31:0];
   endfunction
   task automatic look(input logic [12:0] x, input logic s);
      u_mcs_path_model.load(x, s);
      cy(3);
   endtask
   task automatic rd(input logic [12:0] x, input logic s);
      look(x, s);
      chk(rb, exp_rb(x, s));
      chk(addr_lines, x[11:0]);
   endtask
   // write then mirror into the bench copy
   task automatic wr(input logic [12:0] x, input logic [31:0] v,
                     input logic e);
      u_mcs_path_model.load(x, 1'b0);
      u_mcs_path_model.write(v, e);
      // valid drops for exactly the cycle after the strobe edge
      chk(vld, 1'b0);
      cy(1);
      if (e && x[11:10] != 2'h0 && x[11:10] != 2'h3 && !x[12])
         wrd[x[11:0]][31:0] = v;
      if (e && x[11:10] != 2'h0 && x[11:10] != 2'h3 && x[12])
         wrd[x[11:0]][46:32] = v[14:0];
      if (e && x[11:10] != 2'h3 && x[12])
         flg[x[11:0]] = v[15];
      cy(1);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(20001));
      corner = '{13'h0400, 13'h0800, 13'h0BFF};
      cy(10);
      resetn = 1'b1;
      cy(4);
      chk(men, 1'b1);
      // whole words in both banks, bank edges first
      for (int i = 0; i < 12; i++)
      begin
         a = {1'b0, 2'($urandom_range(2, 1)), 10'($urandom)};
         if (i < 3)
            a = corner[i];
         wr(a, $urandom, 1'b1);
         wr(a | 13'h1000, $urandom, 1'b1);
         wr(a | 13'h1000, $urandom, 1'b0);
         rd(a, 1'b0);
         chk(wd, {flg[a[11:0]], wrd[a[11:0]]});
         rd(a | 13'h1000, 1'b0);
         rd(a | 13'h1000, 1'b1);
         r = a;
      end
      rd(13'h0400, 1'b0);
      // read-only bank: word stays, flag follows
      a = 13'h0155;
      look(a, 1'b0);
      keep = {1'b0, 47'({5{a[9:0]}})}; // fixed pattern of the rom bank
      chk(wd[46:0], keep[46:0]);
      wr(a, 32'hFFFFFFFF, 1'b1);
      for (int f = 1; f >= 0; f--)
      begin
         wr(a | 13'h1000, {16'h0, f[0], 15'h7FFF}, 1'b1);
         look(a, 1'b0);
         chk(wd, {f[0], keep[46:0]});
      end
      look(13'h0C12, 1'b0);
      chk(wd, 48'h0);
      // sequencer takes the address lines
      seq_addr = r[11:0];
      run = 1'b1;
      cy(1);
      run = 1'b0;
      cy(3);
      chk(sen, 1'b1);
      chk(men, 1'b0);
      chk(rb, 32'h0);
      chk(addr_lines, seq_addr);
      chk(wd, {flg[seq_addr], wrd[seq_addr]});
      u_mcs_path_model.write(32'h0, 1'b1);
      cy(1);
      chk(vld, 1'b1);
      clear_req = 1'b1;
      cy(1);
      clear_req = 1'b0;
      cy(3);
      chk(men, 1'b1);
      chk(addr_lines, 12'hC12);
      rd(r, 1'b0);
      report_and_stop();
   end
endmodule // mcs_store_tb_top
